/* src/pclbi_pkg.sv */
// constants shared by the pixel channel bus input design
`default_nettype none
package pclbi_pkg;
   localparam int          CHANS        = 3;
   localparam int          BUS_W        = 32;
   localparam int          BYTE_W       = 8;
   localparam int          LUT_AW       = 8;
   localparam int          LUT_DEPTH    = 256;
   localparam int          LUT_DW       = 18;
   localparam int          FIELD_W      = 6;
   localparam int          RED_LSB      = 12;
   localparam int          GRN_LSB      = 6;
   localparam int          BLU_LSB      = 0;
   localparam int          SEL_W        = 2;
   localparam int          CTL_W        = 4;
   localparam int          CTL_BLANK    = 0;
   localparam int          CTL_VSYNC    = 1;
   localparam int          CTL_CSYNC    = 2;
   localparam int          CTL_ILACE    = 3;
   localparam int          PIPE_SEQ     = 2;
   localparam int          SEQ_DIV      = 4;
   localparam int          SEQ_MAX_MHZ  = 25;
   localparam int          PIX_MAX_MHZ  = 64;
   localparam logic [1:0]  PHASE_LAST   = 2'h3;
   localparam logic [1:0]  PHASE_FIRST  = 2'h0;
   localparam logic        MODE_MUX8    = 1'h1;
   localparam logic        MODE_RESET   = 1'h1;
   localparam logic        LEVEL_IDLE_N = 1'h1;
endpackage : pclbi_pkg
`default_nettype wire

/* src/pclbi_lut_if.sv */
// look-up table access signals between channel logic and table memory
`timescale 1ns/1ns
`default_nettype none
interface pclbi_lut_if
   import pclbi_pkg::*;
();
   logic              wr_en;
   logic              rd_en;
   logic [LUT_AW-1:0] addr_a;
   logic [LUT_DW-1:0] wdata;
   logic [LUT_DW-1:0] rdata_a;
   logic [LUT_AW-1:0] addr_b;
   logic [LUT_DW-1:0] rdata_b;
   modport ctrl (output wr_en, rd_en, addr_a, wdata, addr_b, input rdata_a, rdata_b);
   modport mem  (input wr_en, rd_en, addr_a, wdata, addr_b, output rdata_a, rdata_b);
endinterface : pclbi_lut_if
`default_nettype wire

/* src/pclbi_lut_mem.sv */
// one colour look-up table: processor port and pixel read port
`timescale 1ns/1ns
`default_nettype none
module pclbi_lut_mem
   import pclbi_pkg::*;
(
   input  wire logic  sys_clk_in,
   input  wire logic  pix_clk_in,
   pclbi_lut_if.mem   lut_port
);
   logic [LUT_DW-1:0] mem_q [LUT_DEPTH];
   logic [LUT_DW-1:0] rdata_a_q;
   logic [LUT_DW-1:0] rdata_b_q;

   // 256 entries of 18 bits
   always_ff @(posedge sys_clk_in) begin
      if (lut_port.wr_en) begin
         mem_q[lut_port.addr_a] <= lut_port.wdata;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (lut_port.rd_en) begin
         rdata_a_q <= mem_q[lut_port.addr_a];
      end
   end

   // pixel value addresses the table
   always_ff @(posedge pix_clk_in) begin
      rdata_b_q <= mem_q[lut_port.addr_b];
   end

   assign lut_port.rdata_a = rdata_a_q;
   assign lut_port.rdata_b = rdata_b_q;
endmodule : pclbi_lut_mem
`default_nettype wire

/* src/pclbi_top.sv */
// pixel channel bus input: bus capture, byte multiplexing, colour look-up
`timescale 1ns/1ns
`default_nettype none
module pclbi_top
   import pclbi_pkg::*;
(
   input  wire logic                         sys_clk_in,
   input  wire logic                         sys_rst_in,
   input  wire logic                         pix_clk_in,
   input  wire logic [CHANS-1:0][BUS_W-1:0]  pixel_data_bus_n_in,
   input  wire logic                         blank_in,
   input  wire logic                         vsync_in,
   input  wire logic                         csync_in,
   input  wire logic                         interlace_in,
   input  wire logic                         mode_wr_in,
   input  wire logic                         mode_data_in,
   input  wire logic [SEL_W-1:0]             lut_sel_in,
   input  wire logic [LUT_AW-1:0]            lut_addr_in,
   input  wire logic [LUT_DW-1:0]            lut_wdata_in,
   input  wire logic                         lut_wr_in,
   input  wire logic                         lut_rd_in,
   output logic      [LUT_DW-1:0]            lut_rdata_out,
   output logic                              lut_rvalid_out,
   output logic                              sequence_clock_n_out,
   output logic                              shift_clock_gated_n_out,
   output logic                              early_blank_n_out,
   output logic                              field_sync_n_out,
   output logic                              even_field_n_out,
   output logic      [CHANS-1:0][FIELD_W-1:0] red_out,
   output logic      [CHANS-1:0][FIELD_W-1:0] green_out,
   output logic      [CHANS-1:0][FIELD_W-1:0] blue_out,
   output logic                              sync_n_out
);
   function automatic logic [BYTE_W-1:0] byte_sel(input logic [BUS_W-1:0] word, input logic [1:0] idx);
      byte_sel = word[{idx, 3'h0} +: BYTE_W];
   endfunction : byte_sel

   logic                             mode_q;
   logic                             pix_rst_s1_q;
   logic                             pix_rst_q;
   logic                             mode_s1_q;
   logic                             mode_s2_q;
   logic [CHANS-1:0][BUS_W-1:0]      bus_s1_q;
   logic [CHANS-1:0][BUS_W-1:0]      bus_s2_q;
   logic [CTL_W-1:0]                 ctl_s1_q;
   logic [CTL_W-1:0]                 ctl_s2_q;
   logic [1:0]                       phase_q;
   logic [1:0]                       phase_d;
   logic                             tick;
   logic                             blank_s;
   logic                             vsync_s;
   logic                             csync_s;
   logic                             ilace_s;
   logic                             blank_now;
   logic                             seq_n_q;
   logic                             shift_n_q;
   logic                             blank_word_q;
   logic                             early_blank_n_q;
   logic [PIPE_SEQ-1:0]              blank_pipe_q;
   logic                             display_blank;
   logic                             field_sync_n_q;
   logic                             even_n_q;
   logic                             sync_n_q;
   logic [CHANS-1:0][BUS_W-1:0]      word_q;
   logic [CHANS-1:0][BYTE_W-1:0]     pix_q;
   logic [CHANS-1:0][LUT_DW-1:0]     rgb_q;
   logic [CHANS-1:0][LUT_DW-1:0]     rdata_a_w;
   logic                             rd_pend_q;
   logic [SEL_W-1:0]                 rd_sel_q;
   logic                             rvalid_q;
   logic [LUT_DW-1:0]                rdata_q;
   logic [BUS_W-1:0]                 word_a;

   // processor side: mode register, write only
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mode_q <= MODE_RESET;
      end else if (mode_wr_in) begin
         mode_q <= mode_data_in;
      end
   end

   // table read return, two cycles after the request
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rd_pend_q <= 1'h0;
         rd_sel_q  <= '0;
         rvalid_q  <= 1'h0;
      end else begin
         rd_pend_q <= lut_rd_in;
         rd_sel_q  <= lut_sel_in;
         rvalid_q  <= rd_pend_q;
      end
   end

   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_q <= '0;
      end else if (rd_pend_q) begin
         rdata_q <= (rd_sel_q < SEL_W'(CHANS)) ? rdata_a_w[rd_sel_q] : '0;
      end
   end

   assign lut_rdata_out  = rdata_q;
   assign lut_rvalid_out = rvalid_q;

   // pixel clock domain reset release
   always_ff @(posedge pix_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pix_rst_s1_q <= 1'h1;
         pix_rst_q    <= 1'h1;
      end else begin
         pix_rst_s1_q <= 1'h0;
         pix_rst_q    <= pix_rst_s1_q;
      end
   end

   // two-flop synchronisers for pins and the mode level
   always_ff @(posedge pix_clk_in or posedge pix_rst_q) begin
      if (pix_rst_q) begin
         mode_s1_q <= MODE_RESET;
         mode_s2_q <= MODE_RESET;
         bus_s1_q  <= '0;
         bus_s2_q  <= '0;
         ctl_s1_q  <= '0;
         ctl_s2_q  <= '0;
      end else begin
         mode_s1_q <= mode_q;
         mode_s2_q <= mode_s1_q;
         bus_s1_q  <= pixel_data_bus_n_in;
         bus_s2_q  <= bus_s1_q;
         ctl_s1_q  <= {interlace_in, csync_in, vsync_in, blank_in};
         ctl_s2_q  <= ctl_s1_q;
      end
   end

   assign blank_s = ctl_s2_q[CTL_BLANK];
   assign vsync_s = ctl_s2_q[CTL_VSYNC];
   assign csync_s = ctl_s2_q[CTL_CSYNC];
   assign ilace_s = ctl_s2_q[CTL_ILACE];

   // one phase counter times all channels
   assign phase_d   = phase_q + 2'h1;
   assign tick      = (phase_q == PHASE_LAST);
   assign blank_now = tick ? blank_s : blank_word_q;

   always_ff @(posedge pix_clk_in or posedge pix_rst_q) begin
      if (pix_rst_q) begin
         phase_q <= PHASE_LAST - 2'h1;
      end else begin
         phase_q <= phase_d;
      end
   end

   // sequencing clock: pixel clock over four, free running
   always_ff @(posedge pix_clk_in or posedge pix_rst_q) begin
      if (pix_rst_q) begin
         seq_n_q <= LEVEL_IDLE_N;
      end else begin
         seq_n_q <= phase_d[1];
      end
   end

   // shift clock in phase, parked high over blanking
   always_ff @(posedge pix_clk_in or posedge pix_rst_q) begin
      if (pix_rst_q) begin
         shift_n_q <= LEVEL_IDLE_N;
      end else begin
         shift_n_q <= phase_d[1] | blank_now;
      end
   end

   // strobes change only with the sequencing clock fall
   always_ff @(posedge pix_clk_in or posedge pix_rst_q) begin
      if (pix_rst_q) begin
         blank_word_q    <= 1'h1;
         early_blank_n_q <= 1'h0;
         blank_pipe_q    <= '1;
      end else if (tick) begin
         blank_word_q    <= blank_s;
         early_blank_n_q <= ~blank_s;
         blank_pipe_q    <= {blank_pipe_q[PIPE_SEQ-2:0], blank_s};
      end
   end

   assign display_blank = blank_pipe_q[PIPE_SEQ-1];

   always_ff @(posedge pix_clk_in or posedge pix_rst_q) begin
      if (pix_rst_q) begin
         field_sync_n_q <= LEVEL_IDLE_N;
      end else if (tick) begin
         field_sync_n_q <= ~vsync_s;
      end
   end

   // even field flips as field sync falls; held high when not interlaced
   always_ff @(posedge pix_clk_in or posedge pix_rst_q) begin
      if (pix_rst_q) begin
         even_n_q <= LEVEL_IDLE_N;
      end else if (tick && vsync_s && field_sync_n_q) begin
         even_n_q <= ilace_s ? ~even_n_q : LEVEL_IDLE_N;
      end
   end

   always_ff @(posedge pix_clk_in or posedge pix_rst_q) begin
      if (pix_rst_q) begin
         sync_n_q <= LEVEL_IDLE_N;
      end else begin
         sync_n_q <= ~csync_s;
      end
   end

   assign sequence_clock_n_out    = seq_n_q;
   assign shift_clock_gated_n_out = shift_n_q;
   assign early_blank_n_out       = early_blank_n_q;
   assign field_sync_n_out        = field_sync_n_q;
   assign even_field_n_out        = even_n_q;
   assign sync_n_out              = sync_n_q;
   assign word_a                  = word_q[0];

   // the frame store sync line is wired between connectors only, no logic here

   // channels A, B, C: capture, byte multiplexer, table
   for (genvar ch = 0; ch < CHANS; ch++) begin : g_chan
      pclbi_lut_if u_lut_if ();

      assign u_lut_if.wr_en  = lut_wr_in && (lut_sel_in == SEL_W'(ch));
      assign u_lut_if.rd_en  = lut_rd_in && (lut_sel_in == SEL_W'(ch));
      assign u_lut_if.addr_a = lut_addr_in;
      assign u_lut_if.wdata  = lut_wdata_in;
      assign u_lut_if.addr_b = pix_q[ch];
      assign rdata_a_w[ch]   = u_lut_if.rdata_a;

      // word taken as the sequencing clock falls, back to true polarity
      always_ff @(posedge pix_clk_in or posedge pix_rst_q) begin
         if (pix_rst_q) begin
            word_q[ch] <= '0;
         end else if (tick) begin
            word_q[ch] <= ~bus_s2_q[ch];
         end
      end

      // 8 bpp: byte per pixel clock; 24 bpp: fixed byte of channel A
      always_ff @(posedge pix_clk_in or posedge pix_rst_q) begin
         if (pix_rst_q) begin
            pix_q[ch] <= '0;
         end else if (mode_s2_q == MODE_MUX8) begin
            pix_q[ch] <= byte_sel(word_q[ch], phase_q);
         end else begin
            pix_q[ch] <= byte_sel(word_a, 2'(ch));
         end
      end

      always_ff @(posedge pix_clk_in or posedge pix_rst_q) begin
         if (pix_rst_q) begin
            rgb_q[ch] <= '0;
         end else begin
            rgb_q[ch] <= display_blank ? '0 : u_lut_if.rdata_b;
         end
      end

      // entry split into red, green, blue fields
      assign red_out[ch]   = rgb_q[ch][RED_LSB +: FIELD_W];
      assign green_out[ch] = rgb_q[ch][GRN_LSB +: FIELD_W];
      assign blue_out[ch]  = rgb_q[ch][BLU_LSB +: FIELD_W];

      pclbi_lut_mem u_lut (
         .sys_clk_in (sys_clk_in),
         .pix_clk_in (pix_clk_in),
         .lut_port   (u_lut_if.mem)
      );
   end

   a_seq_clock_shape : assert property (
      @(posedge pix_clk_in) disable iff (pix_rst_q)
      $fell(seq_n_q) |=> !seq_n_q ##1 seq_n_q ##1 seq_n_q ##1 !seq_n_q)
      else $error("sequencing clock shape wrong");

   a_capture_invert : assert property (
      @(posedge pix_clk_in) disable iff (pix_rst_q)
      tick |=> (word_a == ~$past(bus_s2_q[0])) && $fell(seq_n_q))
      else $error("captured word not inverted bus");

   a_shift_parked : assert property (
      @(posedge pix_clk_in) disable iff (pix_rst_q)
      blank_word_q && $stable(blank_word_q) |-> shift_n_q)
      else $error("shift clock runs during blanking");

   a_shift_follows : assert property (
      @(posedge pix_clk_in) disable iff (pix_rst_q)
      !blank_word_q && $stable(blank_word_q) |-> shift_n_q == seq_n_q)
      else $error("shift clock not in phase");

   a_strobe_on_fall : assert property (
      @(posedge pix_clk_in) disable iff (pix_rst_q)
      $changed(early_blank_n_q) || $changed(field_sync_n_q) |-> $fell(seq_n_q))
      else $error("strobe moved off sequencing fall");

   a_early_advance : assert property (
      @(posedge pix_clk_in) disable iff (pix_rst_q)
      $fell(early_blank_n_q) |-> ##4 display_blank)
      else $error("early blank advance wrong");

   a_field_sync_low : assert property (
      @(posedge pix_clk_in) disable iff (pix_rst_q)
      tick && vsync_s |=> !field_sync_n_q)
      else $error("field sync not low in flyback");

   a_even_on_fsync : assert property (
      @(posedge pix_clk_in) disable iff (pix_rst_q)
      $changed(even_n_q) |-> $fell(field_sync_n_q))
      else $error("even field changed off field sync fall");

   a_lsb_first : assert property (
      @(posedge pix_clk_in) disable iff (pix_rst_q)
      (mode_s2_q == MODE_MUX8) && (phase_q == PHASE_FIRST) |=> pix_q[0] == $past(word_a[7:0]))
      else $error("first byte not least significant");

   a_direct_route : assert property (
      @(posedge pix_clk_in) disable iff (pix_rst_q)
      mode_s2_q != MODE_MUX8 |=> pix_q[1] == $past(word_a[15:8]) && pix_q[2] == $past(word_a[23:16]))
      else $error("direct byte routing wrong");

   a_mode_write : assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      mode_wr_in |=> mode_q == $past(mode_data_in))
      else $error("mode register not written");

   a_sync_out : assert property (
      @(posedge pix_clk_in) disable iff (pix_rst_q)
      csync_s |=> !sync_n_q)
      else $error("sync output not low on sync");

   a_lut_read : assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      lut_rd_in && !$past(lut_rd_in) |=> !lut_rvalid_out ##1 lut_rvalid_out)
      else $error("table read answer late");
endmodule : pclbi_top
`default_nettype wire

/* tb/pclbi_frame_store.sv */
// frame store model: drives inverted open-collector words onto a pixel bus
`timescale 1ns/1ns
`default_nettype none
module pclbi_frame_store
   import pclbi_pkg::*;
(
   input  wire logic             shift_clock_gated_n_in,
   input  wire logic             enable_in,
   output logic      [BUS_W-1:0] pull_out
);
   logic [BUS_W-1:0] word_q = '0;

   // new word only on the gated shift clock fall
   always @(negedge shift_clock_gated_n_in) begin
      word_q = enable_in ? BUS_W'($urandom) : '0;
   end

   // released lines float at once to the pull-up, i.e. data zero
   assign pull_out = enable_in ? word_q : '0;
endmodule : pclbi_frame_store
`default_nettype wire

/* tb/tb_pclbi_top.sv */
// testbench for the pixel channel bus input
`timescale 1ns/1ns
`default_nettype none
module tb_pclbi_top
   import pclbi_pkg::*;
;
   logic                          sys_clk_in;
   logic                          pix_clk_in;
   logic                          sys_rst_in   = 1'h1;
   logic [CHANS-1:0][BUS_W-1:0]   pixel_data_bus_n_in;
   logic                          blank_in     = 1'h0;
   logic                          vsync_in     = 1'h0;
   logic                          csync_in     = 1'h0;
   logic                          interlace_in = 1'h0;
   logic                          mode_wr_in   = 1'h0;
   logic                          mode_data_in = 1'h0;
   logic [SEL_W-1:0]              lut_sel_in   = '0;
   logic [LUT_AW-1:0]             lut_addr_in  = '0;
   logic [LUT_DW-1:0]             lut_wdata_in = '0;
   logic                          lut_wr_in    = 1'h0;
   logic                          lut_rd_in    = 1'h0;
   logic [LUT_DW-1:0]             lut_rdata_out;
   logic                          lut_rvalid_out, sequence_clock_n_out, shift_clock_gated_n_out;
   logic                          early_blank_n_out, field_sync_n_out, even_field_n_out, sync_n_out;
   logic [CHANS-1:0][FIELD_W-1:0] red_out, green_out, blue_out;
   logic [3:0][BUS_W-1:0]         pull;
   logic [3:0]                    en           = '0;
   logic                          rec          = 1'h0;
   logic [LUT_DW-1:0]             lut [CHANS][LUT_DEPTH];
   logic [BUS_W-1:0]              wq [CHANS][$];
   logic [LUT_DW-1:0]             oq [CHANS][$];
   logic [LUT_DW-1:0]             eq [CHANS][$];
   int                            n_fail       = 0;
   int                            total_checks = 0;

   // channel A carries two wired-OR sources
   assign pixel_data_bus_n_in[0] = ~(pull[0] | pull[3]);
   assign pixel_data_bus_n_in[1] = ~pull[1];
   assign pixel_data_bus_n_in[2] = ~pull[2];

   pclbi_top pclbi_top_inst (
      .sys_clk_in, .sys_rst_in, .pix_clk_in, .pixel_data_bus_n_in, .blank_in, .vsync_in, .csync_in,
      .interlace_in, .mode_wr_in, .mode_data_in, .lut_sel_in, .lut_addr_in, .lut_wdata_in, .lut_wr_in,
      .lut_rd_in, .lut_rdata_out, .lut_rvalid_out, .sequence_clock_n_out, .shift_clock_gated_n_out,
      .early_blank_n_out, .field_sync_n_out, .even_field_n_out, .red_out, .green_out, .blue_out,
      .sync_n_out
   );

   for (genvar g = 0; g < 4; g++) begin : gen_src
      pclbi_frame_store pclbi_frame_store_inst (
         .shift_clock_gated_n_in(shift_clock_gated_n_out),
         .enable_in             (en[g]),
         .pull_out              (pull[g])
      );
   end

   initial begin
      sys_clk_in = 1'h0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   initial begin
      pix_clk_in = 1'h0;
      #3;
      forever #16 pix_clk_in = ~pix_clk_in;
   end

   // true words as the sources meant them
   always @(negedge shift_clock_gated_n_out) if (rec) begin
      #1;
      for (int c = 0; c < CHANS; c++) wq[c].push_back(c == 0 ? (pull[0] | pull[3]) : pull[c]);
   end
   always @(posedge pix_clk_in) if (rec) begin
      #1;
      for (int c = 0; c < CHANS; c++) oq[c].push_back({red_out[c], green_out[c], blue_out[c]});
   end

   task automatic chk_e(input string n, input logic [LUT_DW-1:0] e, input logic [LUT_DW-1:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk_e

   task automatic chk_b(input string n, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask : chk_b

   task automatic wr(input logic [SEL_W-1:0] s, input logic [LUT_AW-1:0] a, input logic [LUT_DW-1:0] d);
      @(posedge sys_clk_in);
      #1 lut_sel_in = s;
      lut_addr_in = a;
      lut_wdata_in = d;
      lut_wr_in = 1'h1;
      @(posedge sys_clk_in);
      #1 lut_wr_in = 1'h0;
   endtask : wr

   task automatic rd(input logic [SEL_W-1:0] s, input logic [LUT_AW-1:0] a, input logic [LUT_DW-1:0] e);
      @(posedge sys_clk_in);
      #1 lut_sel_in = s;
      lut_addr_in = a;
      lut_rd_in = 1'h1;
      @(posedge sys_clk_in);
      #1 lut_rd_in = 1'h0;
      chk_b("rvalid_early", 1'h0, lut_rvalid_out);
      @(posedge sys_clk_in);
      #1 chk_b("rvalid", 1'h1, lut_rvalid_out);
      chk_e("rdata", e, lut_rdata_out);
   endtask : rd

   task automatic wave(input logic blk);
      logic [15:0] s, h;
      @(posedge sys_clk_in);
      #1 blank_in = blk;
      repeat (64) @(posedge pix_clk_in);
      for (int i = 0; i < 16; i++) begin
         @(posedge pix_clk_in);
         #1 s[i] = sequence_clock_n_out;
         h[i] = shift_clock_gated_n_out;
      end
      for (int i = 0; i < 12; i++) begin
         chk_b("seq_period", s[i], s[i+4]);
         chk_b("seq_duty", ~s[i], s[i+2]);
         chk_b("shift_clock", blk ? 1'h1 : s[i], h[i]);
      end
      chk_b("early_blank", ~blk, early_blank_n_out);
      if (blk) for (int c = 0; c < CHANS; c++) chk_e("blanked_rgb", '0, {red_out[c], green_out[c], blue_out[c]});
   endtask : wave

   task automatic field(input logic il);
      logic e0;
      @(posedge sys_clk_in);
      #1 interlace_in = il;
      repeat (20) @(posedge pix_clk_in);
      #1 e0 = even_field_n_out;
      for (int p = 1; p >= 0; p--) begin
         @(posedge sys_clk_in);
         #1 vsync_in = p[0];
         csync_in = p[0];
         repeat (40) @(posedge pix_clk_in);
         #1 chk_b("field_sync", ~p[0], field_sync_n_out);
         chk_b("sync", ~p[0], sync_n_out);
      end
      chk_b("even_field", il ? ~e0 : 1'h1, even_field_n_out);
   endtask : field

   task automatic stream(input logic m);
      int   i, k;
      logic ok;
      @(posedge sys_clk_in);
      #1 mode_data_in = m;
      mode_wr_in = 1'h1;
      @(posedge sys_clk_in);
      #1 mode_wr_in = 1'h0;
      for (int c = 0; c < CHANS; c++) begin
         wq[c].delete();
         oq[c].delete();
         eq[c].delete();
      end
      repeat (40) @(posedge pix_clk_in);
      @(posedge sys_clk_in);
      #1 en = '1;
      rec = 1'h1;
      repeat (200) @(posedge pix_clk_in);
      @(posedge sys_clk_in);
      #1 rec = 1'h0;
      en = '0;
      for (int n = 0; n < wq[0].size(); n++) for (k = 0; k < 4; k++) for (int c = 0; c < CHANS; c++)
         eq[c].push_back(m ? lut[c][wq[c][n][8*k+:8]] : lut[c][wq[0][n][8*c+:8]]);
      ok = 1'h0;
      for (i = 0; i + 8 < oq[0].size() && !ok; i++) begin
         ok = 1'h1;
         for (k = 0; k < 8; k++) if (oq[0][i+k] !== eq[0][k]) ok = 1'h0;
      end
      chk_b("stream_found", 1'h1, ok);
      for (k = 0; k + 16 < eq[0].size() && i + k <= oq[0].size(); k++)
         for (int c = 0; c < CHANS; c++) chk_e("pixel", eq[c][k], oq[c][i-1+k]);
   endtask : stream

   task automatic conclude();
      if (n_fail == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude

   initial begin
      #400000;
      n_fail++;
      conclude();
   end

   initial begin
      void'($urandom(32'h1e97));
      repeat (16) @(posedge sys_clk_in);
      #1 sys_rst_in = 1'h0;
      repeat (4) @(posedge pix_clk_in);
      for (int c = 0; c < CHANS; c++) for (int a = 0; a < LUT_DEPTH; a++) begin
         lut[c][a] = LUT_DW'($urandom);
         wr(SEL_W'(c), LUT_AW'(a), lut[c][a]);
      end
      wr(2'h3, 8'h05, ~lut[0][5]);
      for (int c = 0; c < CHANS; c++) for (int a = 0; a < LUT_DEPTH; a++)
         rd(SEL_W'(c), LUT_AW'(a), lut[c][a]);
      rd(2'h3, 8'h05, '0);
      wave(1'h1);
      wave(1'h0);
      field(1'h1);
      field(1'h1);
      field(1'h0);
      stream(1'h0);
      stream(1'h1);
      conclude();
   end
endmodule : tb_pclbi_top
`default_nettype wire
